// File: hw/ddc_cfg_pkg.sv
// package: register map, field layout and constants of the output config bank
//
// Functional notes
// - select 0 aligns on each sync pulse; 1 aligns on first pulse only.
// - xor mode: select 0 appends pattern bit and xors; 1 xors with LSB.
// - down converter enable bit 1 enables it, 0 bypasses it.
// - phase word: low register gives 15:0, mixed low byte gives 23:16.
// - frequency word: mixed high byte gives 7:0, high register 23:8.
// - every register field is zero after reset.
package ddc_cfg_pkg;

    localparam int REG_W    = 16;
    localparam int IDX_W    = 8;
    localparam int ADR_W    = 10;
    localparam int ADR_LO   = 2;
    localparam int BYTE_W   = 8;
    localparam int BYTES    = 2;
    localparam int SEL_W    = 4;
    localparam int DAT_W    = 32;
    localparam int WORD_W   = 24;
    localparam int NUM_REGS = 7;
    localparam int SLOT_W   = 3;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_DATA_CLOCK  = 8'hc5;
    localparam logic [IDX_W-1:0] IDX_INIT_PRI    = 8'hf4;
    localparam logic [IDX_W-1:0] IDX_INIT_SEC    = 8'hf6;
    localparam logic [IDX_W-1:0] IDX_DDC_CTRL    = 8'hfb;
    localparam logic [IDX_W-1:0] IDX_PHASE_LOW   = 8'hfc;
    localparam logic [IDX_W-1:0] IDX_PHASE_FREQ  = 8'hfd;
    localparam logic [IDX_W-1:0] IDX_FREQ_HIGH   = 8'hfe;

    // storage slots
    localparam logic [SLOT_W-1:0] SLOT_DATA_CLOCK = 3'h0;
    localparam logic [SLOT_W-1:0] SLOT_INIT_PRI   = 3'h1;
    localparam logic [SLOT_W-1:0] SLOT_INIT_SEC   = 3'h2;
    localparam logic [SLOT_W-1:0] SLOT_DDC_CTRL   = 3'h3;
    localparam logic [SLOT_W-1:0] SLOT_PHASE_LOW  = 3'h4;
    localparam logic [SLOT_W-1:0] SLOT_PHASE_FREQ = 3'h5;
    localparam logic [SLOT_W-1:0] SLOT_FREQ_HIGH  = 3'h6;

    // field positions
    localparam int LANE_CLOCK_BIT  = 9;
    localparam int SLOW_CLOCK_LSB  = 2;
    localparam int SLOW_CLOCK_W    = 2;
    localparam int INIT_BIT        = 1;
    localparam int DDC_EN_BIT      = 0;
    localparam int FAST_LANE_BIT   = 1;
    localparam int XOR_SRC_BIT     = 2;
    localparam int PERIODIC_BIT    = 3;
    localparam int MIX_FREQ_LSB    = 8;

    localparam logic [REG_W-1:0] REG_RESET   = 16'h0000;
    localparam logic [DAT_W-1:0] NO_DATA     = 32'h0000_0000;
    localparam logic [6:0]       PRBS_SEED   = 7'h7f;
    localparam int               PRBS_TAP_HI = 6;
    localparam int               PRBS_TAP_LO = 5;

endpackage

// File: hw/reg_bus_if.sv
// interface: register access strobes between bus slave and register bank
`timescale 1ns/1ps
interface reg_bus_if;
    logic                                     wr_stb;
    logic [ddc_cfg_pkg::IDX_W-1:0]            index;
    logic [ddc_cfg_pkg::BYTES-1:0]            be;
    logic [ddc_cfg_pkg::REG_W-1:0]            wdata;
    logic [ddc_cfg_pkg::REG_W-1:0]            rdata;

    modport slave_side (output wr_stb, index, be, wdata, input rdata);
    modport bank_side  (input wr_stb, index, be, wdata, output rdata);
endinterface

// File: hw/wb_reg_slave.sv
// module: classic wishbone slave, one wait state, writes commit with ack
`timescale 1ns/1ps
module wb_reg_slave (
    input  wire logic                           clk_i,
    input  wire logic                           rst_i,
    input  wire logic                           cyc_i,
    input  wire logic                           stb_i,
    input  wire logic                           we_i,
    input  wire logic [ddc_cfg_pkg::ADR_W-1:0]  adr_i,
    input  wire logic [ddc_cfg_pkg::SEL_W-1:0]  sel_i,
    input  wire logic [ddc_cfg_pkg::DAT_W-1:0]  dat_i,
    output logic      [ddc_cfg_pkg::DAT_W-1:0]  dat_o,
    output logic                                ack_o,
    reg_bus_if.slave_side                       bus
);
    typedef struct packed {
        logic                          ack;
        logic [ddc_cfg_pkg::DAT_W-1:0] dat;
    } slave_state_t;

    localparam slave_state_t SLAVE_RESET = '{ack: 1'b0,
                                             dat: ddc_cfg_pkg::NO_DATA};

    slave_state_t st;
    slave_state_t next_st;
    logic         req;

    always_comb begin
        req        = cyc_i && stb_i;
        next_st    = st;
        next_st.ack = req && !st.ack;
        next_st.dat = ddc_cfg_pkg::NO_DATA;
        if (req && !st.ack && !we_i) begin
            next_st.dat = {{(ddc_cfg_pkg::DAT_W - ddc_cfg_pkg::REG_W){1'b0}},
                           bus.rdata};
        end
        bus.wr_stb = req && we_i && st.ack;
        bus.index  = adr_i[ddc_cfg_pkg::ADR_LO +: ddc_cfg_pkg::IDX_W];
        bus.be     = sel_i[ddc_cfg_pkg::BYTES-1:0];
        bus.wdata  = dat_i[ddc_cfg_pkg::REG_W-1:0];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= SLAVE_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign ack_o = st.ack;
    assign dat_o = st.dat;

    ack_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("ack not a single pulse one cycle after request");
endmodule // wb_reg_slave

// File: hw/output_scrambler.sv
// module: output word builder with pattern-bit or lsb xor scrambling
`timescale 1ns/1ps
module output_scrambler #(
    parameter int DATA_W = 16
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic [DATA_W-1:0] sample_i,
    input  wire logic              valid_i,
    input  wire logic              xor_en_i,
    input  wire logic              src_sel_i,
    output logic      [DATA_W:0]   data_o,
    output logic                   valid_o
);
    typedef struct packed {
        logic [6:0]      lfsr;
        logic [DATA_W:0] data;
        logic            valid;
    } scr_state_t;

    localparam scr_state_t SCR_RESET = '{lfsr: ddc_cfg_pkg::PRBS_SEED,
                                         data: '0, valid: 1'b0};

    scr_state_t st;
    scr_state_t next_st;
    logic       pbit;

    always_comb begin
        pbit          = st.lfsr[ddc_cfg_pkg::PRBS_TAP_HI];
        next_st       = st;
        next_st.valid = valid_i;
        if (valid_i) begin
            next_st.lfsr = {st.lfsr[5:0],
                            st.lfsr[ddc_cfg_pkg::PRBS_TAP_HI] ^
                            st.lfsr[ddc_cfg_pkg::PRBS_TAP_LO]};
            if (!xor_en_i) begin
                next_st.data = {sample_i, 1'b0};
            end else if (!src_sel_i) begin
                next_st.data = {sample_i ^ {DATA_W{pbit}}, pbit};
            end else begin
                next_st.data = {sample_i[DATA_W-1:1]
                                    ^ {(DATA_W-1){sample_i[0]}},
                                sample_i[0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= SCR_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign data_o  = st.data;
    assign valid_o = st.valid;

    pattern_xor_a: assert property (@(posedge clk_i) disable iff (rst_i)
        valid_i && xor_en_i && !src_sel_i |=>
        data_o == {$past(sample_i) ^ {DATA_W{$past(pbit)}},
                   $past(pbit)})
        else $error("pattern bit xor output wrong");
    lsb_xor_a: assert property (@(posedge clk_i) disable iff (rst_i)
        valid_i && xor_en_i && src_sel_i |=>
        data_o[DATA_W:1] == ($past(sample_i) ^ {DATA_W{$past(sample_i[0])}})
            + {{(DATA_W-1){1'b0}}, $past(sample_i[0])})
        else $error("lsb xor output wrong");
endmodule // output_scrambler

// File: hw/ddc_output_config.sv
// module: down converter output configuration bank with sync aligner
`timescale 1ns/1ps
module ddc_output_config #(
    parameter int SAMPLE_W = 16
) (
    input  wire logic                                clk_i,
    input  wire logic                                rst_i,
    input  wire logic                                wb_cyc_i,
    input  wire logic                                wb_stb_i,
    input  wire logic                                wb_we_i,
    input  wire logic [ddc_cfg_pkg::ADR_W-1:0]       wb_adr_i,
    input  wire logic [ddc_cfg_pkg::SEL_W-1:0]       wb_sel_i,
    input  wire logic [ddc_cfg_pkg::DAT_W-1:0]       wb_dat_i,
    output logic      [ddc_cfg_pkg::DAT_W-1:0]       wb_dat_o,
    output logic                                     wb_ack_o,
    input  wire logic                                sample_sync_pin_i,
    input  wire logic [SAMPLE_W-1:0]                 sample_i,
    input  wire logic                                sample_valid_i,
    input  wire logic                                xor_output_i,
    output logic                                     lane_clock_select_o,
    output logic [ddc_cfg_pkg::SLOW_CLOCK_W-1:0]     slow_variant_clock_field_o,
    output logic                                     fast_variant_lane_bit_o,
    output logic                                     init_primary_o,
    output logic                                     init_secondary_o,
    output logic                                     downconverter_enable_o,
    output logic                                     periodic_sync_select_o,
    output logic                                     scramble_source_o,
    output logic [ddc_cfg_pkg::WORD_W-1:0]           oscillator_phase_word_o,
    output logic [ddc_cfg_pkg::WORD_W-1:0]           oscillator_frequency_word_o,
    output logic                                     osc_align_o,
    output logic [SAMPLE_W:0]                        out_data_o,
    output logic                                     out_valid_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [ddc_cfg_pkg::NUM_REGS-1:0][ddc_cfg_pkg::REG_W-1:0] regs;
        logic                                                     sync_prev;
        logic                                                     sync_armed;
        logic                                                     align;
    } bank_state_t;

    localparam bank_state_t BANK_RESET = '{
        regs:       {ddc_cfg_pkg::NUM_REGS{ddc_cfg_pkg::REG_RESET}},
        sync_prev:  1'b0,
        sync_armed: 1'b1,
        align:      1'b0
    };

    bank_state_t                     st;
    bank_state_t                     next_st;
    logic                            hit;
    logic [ddc_cfg_pkg::SLOT_W-1:0]  slot;
    logic                            sync_rise;
    logic                            periodic;
    logic                            ctrl_wr;

    reg_bus_if bus ();

    // ------------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------------
    wb_reg_slave u_slave (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .cyc_i (wb_cyc_i),
        .stb_i (wb_stb_i),
        .we_i  (wb_we_i),
        .adr_i (wb_adr_i),
        .sel_i (wb_sel_i),
        .dat_i (wb_dat_i),
        .dat_o (wb_dat_o),
        .ack_o (wb_ack_o),
        .bus   (bus.slave_side)
    );

    // ------------------------------------------------------------------
    // register decode, write and sync alignment
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        hit     = 1'b1;
        slot    = ddc_cfg_pkg::SLOT_DATA_CLOCK;
        case (bus.index)
            ddc_cfg_pkg::IDX_DATA_CLOCK: begin
                slot = ddc_cfg_pkg::SLOT_DATA_CLOCK;
            end
            ddc_cfg_pkg::IDX_INIT_PRI: begin
                slot = ddc_cfg_pkg::SLOT_INIT_PRI;
            end
            ddc_cfg_pkg::IDX_INIT_SEC: begin
                slot = ddc_cfg_pkg::SLOT_INIT_SEC;
            end
            ddc_cfg_pkg::IDX_DDC_CTRL: begin
                slot = ddc_cfg_pkg::SLOT_DDC_CTRL;
            end
            ddc_cfg_pkg::IDX_PHASE_LOW: begin
                slot = ddc_cfg_pkg::SLOT_PHASE_LOW;
            end
            ddc_cfg_pkg::IDX_PHASE_FREQ: begin
                slot = ddc_cfg_pkg::SLOT_PHASE_FREQ;
            end
            ddc_cfg_pkg::IDX_FREQ_HIGH: begin
                slot = ddc_cfg_pkg::SLOT_FREQ_HIGH;
            end
            default: begin
                hit = 1'b0;
            end
        endcase

        // unmapped reads answer zero, unmapped writes are dropped
        bus.rdata = hit ? st.regs[slot] : ddc_cfg_pkg::REG_RESET;

        if (bus.wr_stb && hit) begin
            for (int b = 0; b < ddc_cfg_pkg::BYTES; b++) begin
                if (bus.be[b]) begin
                    next_st.regs[slot][b*ddc_cfg_pkg::BYTE_W
                                       +: ddc_cfg_pkg::BYTE_W]
                        = bus.wdata[b*ddc_cfg_pkg::BYTE_W +: ddc_cfg_pkg::BYTE_W];
                end
            end
        end

        ctrl_wr  = bus.wr_stb && hit && (slot == ddc_cfg_pkg::SLOT_DDC_CTRL);
        periodic = st.regs[ddc_cfg_pkg::SLOT_DDC_CTRL][ddc_cfg_pkg::PERIODIC_BIT];

        // single mode aligns on every pulse, periodic mode on the first only
        sync_rise         = sample_sync_pin_i && !st.sync_prev;
        next_st.sync_prev = sample_sync_pin_i;
        next_st.align     = sync_rise && (!periodic || st.sync_armed);
        if (!periodic) begin
            next_st.sync_armed = 1'b1;
        end else if (sync_rise) begin
            next_st.sync_armed = 1'b0;
        end
        // rewriting the control register starts a new pulse train
        if (ctrl_wr) begin
            next_st.sync_armed = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= BANK_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // configuration outputs
    // ------------------------------------------------------------------
    assign lane_clock_select_o =
        st.regs[ddc_cfg_pkg::SLOT_DATA_CLOCK][ddc_cfg_pkg::LANE_CLOCK_BIT];
    assign slow_variant_clock_field_o =
        st.regs[ddc_cfg_pkg::SLOT_DATA_CLOCK]
               [ddc_cfg_pkg::SLOW_CLOCK_LSB +: ddc_cfg_pkg::SLOW_CLOCK_W];
    assign fast_variant_lane_bit_o =
        st.regs[ddc_cfg_pkg::SLOT_DDC_CTRL][ddc_cfg_pkg::FAST_LANE_BIT];
    assign init_primary_o =
        st.regs[ddc_cfg_pkg::SLOT_INIT_PRI][ddc_cfg_pkg::INIT_BIT];
    assign init_secondary_o =
        st.regs[ddc_cfg_pkg::SLOT_INIT_SEC][ddc_cfg_pkg::INIT_BIT];
    assign downconverter_enable_o =
        st.regs[ddc_cfg_pkg::SLOT_DDC_CTRL][ddc_cfg_pkg::DDC_EN_BIT];
    assign periodic_sync_select_o = periodic;
    assign scramble_source_o =
        st.regs[ddc_cfg_pkg::SLOT_DDC_CTRL][ddc_cfg_pkg::XOR_SRC_BIT];
    assign osc_align_o = st.align;

    // phase: low register under the low byte of the mixed register
    assign oscillator_phase_word_o = {
        st.regs[ddc_cfg_pkg::SLOT_PHASE_FREQ][ddc_cfg_pkg::BYTE_W-1:0],
        st.regs[ddc_cfg_pkg::SLOT_PHASE_LOW]};
    // frequency: high register over the high byte of the mixed register
    assign oscillator_frequency_word_o = {
        st.regs[ddc_cfg_pkg::SLOT_FREQ_HIGH],
        st.regs[ddc_cfg_pkg::SLOT_PHASE_FREQ]
               [ddc_cfg_pkg::MIX_FREQ_LSB +: ddc_cfg_pkg::BYTE_W]};

    // ------------------------------------------------------------------
    // output word scrambling
    // ------------------------------------------------------------------
    output_scrambler #(
        .DATA_W (SAMPLE_W)
    ) u_scrambler (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .sample_i  (sample_i),
        .valid_i   (sample_valid_i),
        .xor_en_i  (xor_output_i),
        .src_sel_i (scramble_source_o),
        .data_o    (out_data_o),
        .valid_o   (out_valid_o)
    );

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence sync_edge_s;
        sample_sync_pin_i && !$past(sample_sync_pin_i);
    endsequence

    sequence full_write_s(logic [ddc_cfg_pkg::IDX_W-1:0] idx);
        bus.wr_stb && bus.index == idx && (&bus.be);
    endsequence

    reset_zero_a: assert property (
        $past(rst_i) |-> st.regs == '0 && oscillator_phase_word_o == '0
            && oscillator_frequency_word_o == '0 && !osc_align_o)
        else $error("bank not zero after reset");

    phase_low_a: assert property (
        full_write_s(ddc_cfg_pkg::IDX_PHASE_LOW) |=>
        oscillator_phase_word_o[ddc_cfg_pkg::REG_W-1:0] == $past(bus.wdata))
        else $error("phase low half not taken");

    mixed_split_a: assert property (
        full_write_s(ddc_cfg_pkg::IDX_PHASE_FREQ) |=>
        oscillator_frequency_word_o[ddc_cfg_pkg::BYTE_W-1:0]
            == $past(bus.wdata[ddc_cfg_pkg::REG_W-1:ddc_cfg_pkg::BYTE_W])
        && oscillator_phase_word_o[ddc_cfg_pkg::WORD_W-1:ddc_cfg_pkg::REG_W]
            == $past(bus.wdata[ddc_cfg_pkg::BYTE_W-1:0]))
        else $error("mixed register split wrong");

    freq_high_a: assert property (
        full_write_s(ddc_cfg_pkg::IDX_FREQ_HIGH) |=>
        oscillator_frequency_word_o[ddc_cfg_pkg::WORD_W-1:ddc_cfg_pkg::BYTE_W]
            == $past(bus.wdata))
        else $error("frequency high half not taken");

    ddc_enable_a: assert property (
        ctrl_wr && bus.be[0] |=>
        downconverter_enable_o == $past(bus.wdata[ddc_cfg_pkg::DDC_EN_BIT]))
        else $error("down converter enable not following write");

    single_align_a: assert property (
        (!periodic) and sync_edge_s |=> osc_align_o)
        else $error("single mode pulse not aligned");

    no_spurious_a: assert property (
        !(sample_sync_pin_i && !st.sync_prev) |=> !osc_align_o)
        else $error("alignment without a sync edge");

    first_only_a: assert property (
        $past(periodic && !ctrl_wr) && periodic && !ctrl_wr && osc_align_o
        ##1 (periodic && !ctrl_wr)[*2] |-> !osc_align_o)
        else $error("periodic mode aligned twice");

endmodule // ddc_output_config

// File: testbench/host_model.sv
// partner model: wishbone host that programs the configuration bank
`timescale 1ns/1ps
module host_model (
    input  wire logic        clk_i,
    input  wire logic [31:0] dat_i,
    input  wire logic        ack_i,
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [9:0]       adr_o,
    output logic [3:0]       sel_o,
    output logic [31:0]      dat_o
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 10'h000;
        sel_o = 4'h0;
        dat_o = 32'h0000_0000;
    end

    // --------------------------------------------------------------
    // field values a well-behaved host writes
    // --------------------------------------------------------------
    function automatic logic [15:0] legal_bits(input logic [7:0] idx);
        case (idx)
            8'hc5:        return 16'h020c;
            8'hf4, 8'hf6: return 16'h0002;
            8'hfb:        return 16'h000f;
            default:      return 16'hffff;
        endcase
    endfunction

    function automatic logic [15:0] lane_word(input int lanes,
                                              input logic slow_member,
                                              input logic two_lane);
        lane_word = 16'h0000;
        lane_word[9] = (lanes == 5 || lanes == 7);
        lane_word[3:2] = (slow_member && !two_lane) ? 2'h3 : 2'h0;
    endfunction

    // --------------------------------------------------------------
    // one classic cycle, held until ack is sampled high
    // --------------------------------------------------------------
    task automatic access(input logic we, input logic [7:0] idx,
                          input logic [15:0] d, output logic [15:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= we;
        adr_o <= {idx, 2'b00};
        sel_o <= 4'h3;
        dat_o <= {16'h0000, d & legal_bits(idx)};
        do begin
            @(posedge clk_i);
        end while (ack_i !== 1'b1);
        q = dat_i[15:0];
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o  <= 1'b0;
        #1;
    endtask

    task automatic init_seq(input logic on);
        logic [15:0] q;
        access(1'b1, 8'hf4, {14'h0000, on, 1'b0}, q);
        access(1'b1, 8'hf6, {14'h0000, on, 1'b0}, q);
    endtask
endmodule // host_model

// File: testbench/adc_ddc_output_config_regs_bench.sv
// testbench: register bank, sync aligner and scrambler of the config block
`timescale 1ns/1ps
module adc_ddc_output_config_regs_bench;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc, stb, we, ack, sync_pin = 1'b0, valid = 1'b0;
    logic        xor_on = 1'b0, lane_clk, fast_lane, init_pri, init_sec;
    logic        ddc_en, periodic, scr_src, align, out_valid;
    logic [9:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat;
    logic [15:0] sample = 16'h0000;
    logic [1:0]  slow_field;
    logic [23:0] phase, freq;
    logic [16:0] out_data;
    logic [6:0]  lfsr = 7'h7f;
    int          num_errors = 0;
    int          total_checks = 0;

    host_model host (.clk_i(clk_i), .dat_i(rdat), .ack_i(ack), .cyc_o(cyc),
        .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

    ddc_output_config uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .sample_sync_pin_i(sync_pin), .sample_i(sample),
        .sample_valid_i(valid), .xor_output_i(xor_on),
        .lane_clock_select_o(lane_clk),
        .slow_variant_clock_field_o(slow_field),
        .fast_variant_lane_bit_o(fast_lane), .init_primary_o(init_pri),
        .init_secondary_o(init_sec), .downconverter_enable_o(ddc_en),
        .periodic_sync_select_o(periodic), .scramble_source_o(scr_src),
        .oscillator_phase_word_o(phase), .oscillator_frequency_word_o(freq),
        .osc_align_o(align), .out_data_o(out_data), .out_valid_o(out_valid));

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    // --------------------------------------------------------------
    // shared helpers
    // --------------------------------------------------------------
    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [15:0] d);
        logic [15:0] q;
        host.access(1'b1, idx, d, q);
    endtask

    task automatic sync_pulse(output int n);
        n = 0;
        @(posedge clk_i) sync_pin <= 1'b1;
        @(posedge clk_i) sync_pin <= 1'b0;
        repeat (4) @(posedge clk_i) n += (align === 1'b1);
    endtask

    // pattern steps once per accepted sample
    task automatic send(input logic [15:0] s, output logic [16:0] o,
                        output logic p);
        p = lfsr[6];
        lfsr = {lfsr[5:0], lfsr[6] ^ lfsr[5]};
        @(posedge clk_i) begin
            sample <= s;
            valid  <= 1'b1;
        end
        @(posedge clk_i) valid <= 1'b0;
        #1 o = out_data;
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic reset_values();
        logic [7:0] idx[8] = '{8'hc5, 8'hf4, 8'hf6, 8'hfb, 8'hfc, 8'hfd,
                               8'hfe, 8'h10};
        logic [15:0] q;
        check("outputs", {phase, freq, lane_clk, slow_field, fast_lane,
              init_pri, init_sec, ddc_en, periodic, scr_src}, 0);
        foreach (idx[i]) begin
            host.access(1'b0, idx[i], 16'h0000, q);
            check("reset read", q, 0);
        end
        wr(8'h10, 16'hffff);
        host.access(1'b0, 8'h10, 16'h0000, q);
        check("unmapped read", q, 0);
    endtask

    task automatic lane_config();
        int lanes[4] = '{0, 2, 5, 7};
        logic [15:0] w, q;
        foreach (lanes[i]) begin
            w = host.lane_word(lanes[i], 1'b1, i[0]);
            wr(8'hc5, w);
            check("lane clock", lane_clk, lanes[i] > 4);
            check("slow field", slow_field, i[0] ? 2'h0 : 2'h3);
            host.access(1'b0, 8'hc5, 16'h0000, q);
            check("lane readback", q, w);
        end
    endtask

    task automatic init_and_words();
        host.init_seq(1'b1);
        check("init on", {init_pri, init_sec}, 2'h3);
        host.init_seq(1'b0);
        check("init off", {init_pri, init_sec}, 2'h0);
        wr(8'hfc, 16'h1234);
        wr(8'hfd, 16'habcd);
        wr(8'hfe, 16'h5678);
        check("phase word", phase, 24'hcd1234);
        check("freq word", freq, 24'h5678ab);
    endtask

    task automatic ctrl_and_sync();
        int n;
        for (int v = 0; v < 16; v++) begin
            wr(8'hfb, v[15:0]);
            check("ddc enable", ddc_en, v[0]);
            check("ctrl fields", {periodic, scr_src, fast_lane},
                  v[3:1]);
        end
        for (int m = 0; m < 2; m++) begin
            wr(8'hfb, m ? 16'h0008 : 16'h0000);
            sync_pulse(n);
            check("first align", n, 1);
            sync_pulse(n);
            check("second align", n, m ? 0 : 1);
        end
    endtask

    task automatic scramble();
        logic [16:0] o;
        logic p;
        send(16'h1235, o, p);
        check("plain word", o, {16'h1235, 1'b0});
        @(posedge clk_i) xor_on <= 1'b1;
        wr(8'hfb, 16'h0000);
        repeat (3) begin
            send(16'ha5c3, o, p);
            check("pattern xor", o, {16'ha5c3 ^ {16{p}}, p});
        end
        wr(8'hfb, 16'h0004);
        send(16'h1235, o, p);
        check("lsb xor one", o, {15'h091a ^ 15'h7fff, 2'b10});
        send(16'h8004, o, p);
        check("lsb xor zero", o, {15'h4002, 2'b00});
        check("out valid", out_valid, 1'b1);
    endtask

    task automatic wrap_up();
        if (num_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        reset_values();
        lane_config();
        init_and_words();
        ctrl_and_sync();
        scramble();
        wrap_up();
    end

    initial begin
        #100000;
        num_errors++;
        wrap_up();
    end
endmodule // adc_ddc_output_config_regs_bench
